// [rtl/pdsr_pkg.sv]
// Package for the power-down and timing-reference control registers.
// Assumes 8-bit register addresses and 8-bit register data.
`default_nettype none

package pdsr_pkg;

    // Register offsets
    localparam logic [7:0] PDSR_OFS_PWR_DOWN = 8'h26;
    localparam logic [7:0] PDSR_OFS_IN_COUPL = 8'h4f;
    localparam logic [7:0] PDSR_OFS_SR_LEVEL = 8'h53;
    localparam logic [7:0] PDSR_OFS_SR_SRC   = 8'h54;

    // Field positions, power_down_control
    localparam int PDSR_POS_GLOBAL_PD = 7;
    localparam int PDSR_POS_PIN_OVR   = 6;
    localparam int PDSR_POS_MASK_SEL  = 5;

    // Field position, input_coupling_select
    localparam int PDSR_POS_IN_DC = 0;

    // Field positions, sync_ref_level_control
    localparam int PDSR_POS_SR_HICM  = 1;
    localparam int PDSR_POS_SR_LEVEL = 0;

    // Field positions, sync_ref_source_and_mask
    localparam int PDSR_POS_SR_SW_EN   = 7;
    localparam int PDSR_POS_SR_MASK_HI = 5;
    localparam int PDSR_POS_SR_MASK_LO = 4;

    // Reset value shared by all four registers
    localparam logic [7:0] PDSR_RST_VAL = 8'h00;

    // Mask field code that blocks the reference entirely
    localparam logic [1:0] PDSR_SR_MASK_ALL = 2'h3;

    // Converter-core nibble that powers a channel down
    localparam logic [3:0] PDSR_CORE_PD_NIB = 4'hf;

endpackage

`default_nettype wire

// [rtl/pdsr_sync_ref_path.sv]
// Internal timing-reference source select and masking.
// Assumes the pin level is already resolved and synchronous.
`default_nettype none

module pdsr_sync_ref_path
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    // Controls from the register bank
    input  wire logic       i_sw_enable,
    input  wire logic       i_sw_level,
    input  wire logic [1:0] i_mask_field,
    // Pin level of the differential pair
    input  wire logic       i_pin_level,
    // Reference seen by the core
    output logic            o_sync_ref
);
    import pdsr_pkg::*;

    logic sync_ref_r;   // Registered internal reference
    logic sync_ref_nxt; // Its next value

    // Pick the source, then apply the mask
    always_comb
    begin
        sync_ref_nxt = i_sw_enable ? i_sw_level : i_pin_level;
        if (i_mask_field == PDSR_SR_MASK_ALL)
        begin
            sync_ref_nxt = 1'b0;
        end
    end

    // Register so glitches of the mux never reach the core
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            sync_ref_r <= 1'b0;
        else
            sync_ref_r <= sync_ref_nxt;
    end

    assign o_sync_ref = sync_ref_r;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_sw_drive;
        i_sw_enable && (i_mask_field != PDSR_SR_MASK_ALL);
    endsequence

    chk_sw_level_drives: assert property (
        s_sw_drive |=> o_sync_ref == $past(i_sw_level))
        else $error("software level not driven onto reference");

    chk_pin_when_auto: assert property (
        !i_sw_enable && (i_mask_field != PDSR_SR_MASK_ALL)
        |=> o_sync_ref == $past(i_pin_level))
        else $error("pin level not passed while software source off");

    chk_mask_blocks_all: assert property (
        (i_mask_field == PDSR_SR_MASK_ALL) [*2] |-> !o_sync_ref)
        else $error("masked reference still reached the core");

endmodule

`default_nettype wire

// [rtl/pdsr_regs.sv]
// Power-down and timing-reference control register bank.
// Assumes a serial-interface front end already decoded
// frames into one-cycle write and read strobes.
`default_nettype none

module pdsr_regs
#(
    parameter int ADDR_W = 8, // Register address width
    parameter int DATA_W = 8  // Register data width
)
(
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_rstn,
    // Register access strobes
    input  wire logic              i_reg_wr_en,
    input  wire logic              i_reg_rd_en,
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic [DATA_W-1:0] i_reg_wr_data,
    output logic      [DATA_W-1:0] o_reg_rd_data,
    output logic                   o_reg_rd_valid,
    // Pins and neighbouring controls
    input  wire logic              i_powerdown_pin,
    input  wire logic              i_sync_ref_pin,
    input  wire logic              i_mask_powerdown_enable,
    input  wire logic [DATA_W-1:0] i_mask1_core,
    input  wire logic [DATA_W-1:0] i_mask2_core,
    // Controls into the converter
    output logic                   o_global_powerdown,
    output logic                   o_channel_one_powerdown,
    output logic                   o_channel_two_powerdown,
    output logic                   o_common_mode_output_raise,
    output logic                   o_sync_ref_high_common_mode_enable,
    output logic                   o_sync_ref_internal
);
    import pdsr_pkg::*;

    // The field positions assume exactly one byte
    if (DATA_W != 8)
        $error("pdsr_regs serves 8-bit data only");
    if (ADDR_W < 7)
        $error("pdsr_regs needs at least 7 address bits");

    // Offset match, used by both write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0]        ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // A channel goes down when its nibble is all ones
    function automatic logic nib_pd(input logic [3:0] nib);
        nib_pd = (nib == PDSR_CORE_PD_NIB);
    endfunction

    // Stored fields; reserved bits have no storage at all
    logic       global_pd_r;    // global_powerdown_bit
    logic       pin_ovr_r;      // pin_powerdown_override
    logic       mask_sel_r;     // powerdown_mask_select
    logic       in_dc_r;        // input_coupling_select_bit
    logic       sr_hicm_r;      // sync_ref_high_common_mode_enable
    logic       sr_level_r;     // software_sync_ref_level
    logic       sr_sw_en_r;     // software_sync_ref_enable
    logic [1:0] sr_mask_r;      // sync_ref_ignore_field
    logic       global_pd_nxt;
    logic       pin_ovr_nxt;
    logic       mask_sel_nxt;
    logic       in_dc_nxt;
    logic       sr_hicm_nxt;
    logic       sr_level_nxt;
    logic       sr_sw_en_nxt;
    logic [1:0] sr_mask_nxt;

    // Write decode: each register keeps its value unless hit
    always_comb
    begin
        global_pd_nxt = global_pd_r;
        pin_ovr_nxt   = pin_ovr_r;
        mask_sel_nxt  = mask_sel_r;
        in_dc_nxt     = in_dc_r;
        sr_hicm_nxt   = sr_hicm_r;
        sr_level_nxt  = sr_level_r;
        sr_sw_en_nxt  = sr_sw_en_r;
        sr_mask_nxt   = sr_mask_r;
        if (i_reg_wr_en)
        begin
            if (hit(i_reg_addr, PDSR_OFS_PWR_DOWN))
            begin
                pin_ovr_nxt  = i_reg_wr_data[PDSR_POS_PIN_OVR];
                mask_sel_nxt = i_reg_wr_data[PDSR_POS_MASK_SEL];
                // The global bit only takes once the override is
                // set, or is set by this very write
                if (pin_ovr_r || i_reg_wr_data[PDSR_POS_PIN_OVR])
                    global_pd_nxt = i_reg_wr_data[PDSR_POS_GLOBAL_PD];
                else
                    global_pd_nxt = 1'b0;
            end
            if (hit(i_reg_addr, PDSR_OFS_IN_COUPL))
            begin
                in_dc_nxt = i_reg_wr_data[PDSR_POS_IN_DC];
            end
            if (hit(i_reg_addr, PDSR_OFS_SR_LEVEL))
            begin
                sr_hicm_nxt  = i_reg_wr_data[PDSR_POS_SR_HICM];
                sr_level_nxt = i_reg_wr_data[PDSR_POS_SR_LEVEL];
            end
            if (hit(i_reg_addr, PDSR_OFS_SR_SRC))
            begin
                sr_sw_en_nxt = i_reg_wr_data[PDSR_POS_SR_SW_EN];
                // Codes 01 and 10 are stored as written; only 11 masks
                sr_mask_nxt  = i_reg_wr_data[PDSR_POS_SR_MASK_HI:PDSR_POS_SR_MASK_LO];
            end
        end
    end

    // Register the fields; everything starts at zero
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            global_pd_r <= PDSR_RST_VAL[PDSR_POS_GLOBAL_PD];
            pin_ovr_r   <= PDSR_RST_VAL[PDSR_POS_PIN_OVR];
            mask_sel_r  <= PDSR_RST_VAL[PDSR_POS_MASK_SEL];
            in_dc_r     <= PDSR_RST_VAL[PDSR_POS_IN_DC];
            sr_hicm_r   <= PDSR_RST_VAL[PDSR_POS_SR_HICM];
            sr_level_r  <= PDSR_RST_VAL[PDSR_POS_SR_LEVEL];
            sr_sw_en_r  <= PDSR_RST_VAL[PDSR_POS_SR_SW_EN];
            sr_mask_r   <= PDSR_RST_VAL[PDSR_POS_SR_MASK_HI:PDSR_POS_SR_MASK_LO];
        end
        else
        begin
            global_pd_r <= global_pd_nxt;
            pin_ovr_r   <= pin_ovr_nxt;
            mask_sel_r  <= mask_sel_nxt;
            in_dc_r     <= in_dc_nxt;
            sr_hicm_r   <= sr_hicm_nxt;
            sr_level_r  <= sr_level_nxt;
            sr_sw_en_r  <= sr_sw_en_nxt;
            sr_mask_r   <= sr_mask_nxt;
        end
    end

    // Read path state
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic              rd_valid_r;
    logic              rd_valid_nxt;

    // Read mux: reserved bits and unmapped offsets read zero.
    // A read and a write in one cycle returns the old value.
    always_comb
    begin
        rd_data_nxt  = rd_data_r;
        rd_valid_nxt = i_reg_rd_en;
        if (i_reg_rd_en)
        begin
            rd_data_nxt = '0;
            if (hit(i_reg_addr, PDSR_OFS_PWR_DOWN))
            begin
                rd_data_nxt[PDSR_POS_GLOBAL_PD] = global_pd_r;
                rd_data_nxt[PDSR_POS_PIN_OVR]   = pin_ovr_r;
                rd_data_nxt[PDSR_POS_MASK_SEL]  = mask_sel_r;
            end
            else if (hit(i_reg_addr, PDSR_OFS_IN_COUPL))
            begin
                rd_data_nxt[PDSR_POS_IN_DC] = in_dc_r;
            end
            else if (hit(i_reg_addr, PDSR_OFS_SR_LEVEL))
            begin
                rd_data_nxt[PDSR_POS_SR_HICM]  = sr_hicm_r;
                rd_data_nxt[PDSR_POS_SR_LEVEL] = sr_level_r;
            end
            else if (hit(i_reg_addr, PDSR_OFS_SR_SRC))
            begin
                rd_data_nxt[PDSR_POS_SR_SW_EN] = sr_sw_en_r;
                rd_data_nxt[PDSR_POS_SR_MASK_HI:PDSR_POS_SR_MASK_LO] = sr_mask_r;
            end
            else
            begin
                rd_data_nxt = '0; // Unmapped offset
            end
        end
    end

    // Read data holds until the next read
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rd_data_r  <= '0;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign o_reg_rd_data  = rd_data_r;
    assign o_reg_rd_valid = rd_valid_r;

    // Converter control outputs
    logic              gpd_r;
    logic              gpd_nxt;
    logic              ch1_pd_r;
    logic              ch1_pd_nxt;
    logic              ch2_pd_r;
    logic              ch2_pd_nxt;
    logic              cm_raise_r;
    logic              cm_raise_nxt;
    logic              hicm_r;
    logic              hicm_nxt;
    logic [DATA_W-1:0] sel_mask;   // Mask byte now in force

    // Derive the control levels from fields and pins
    always_comb
    begin
        // Override hands power-down to the register, else the pin
        gpd_nxt  = pin_ovr_r ? global_pd_r : i_powerdown_pin;
        sel_mask = mask_sel_r ? i_mask2_core : i_mask1_core;
        // Mask-driven power-down only while its enable is set
        ch1_pd_nxt = i_mask_powerdown_enable && nib_pd(sel_mask[7:4]);
        ch2_pd_nxt = i_mask_powerdown_enable && nib_pd(sel_mask[3:0]);
        // Raise is the default; DC coupling turns it off
        cm_raise_nxt = !in_dc_r;
        hicm_nxt     = sr_hicm_r;
    end

    // Registered so the analog side sees clean levels
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            gpd_r      <= 1'b0;
            ch1_pd_r   <= 1'b0;
            ch2_pd_r   <= 1'b0;
            cm_raise_r <= 1'b0;
            hicm_r     <= 1'b0;
        end
        else
        begin
            gpd_r      <= gpd_nxt;
            ch1_pd_r   <= ch1_pd_nxt;
            ch2_pd_r   <= ch2_pd_nxt;
            cm_raise_r <= cm_raise_nxt;
            hicm_r     <= hicm_nxt;
        end
    end

    assign o_global_powerdown                 = gpd_r;
    assign o_channel_one_powerdown            = ch1_pd_r;
    assign o_channel_two_powerdown            = ch2_pd_r;
    assign o_common_mode_output_raise         = cm_raise_r;
    assign o_sync_ref_high_common_mode_enable = hicm_r;

    // Reference source select and masking; the host is expected
    // to enable the software source before toggling the level
    pdsr_sync_ref_path u_sync_ref_path
    (
        .i_ref_clk    (i_ref_clk),
        .i_rstn       (i_rstn),
        .i_sw_enable  (sr_sw_en_r),
        .i_sw_level   (sr_level_r),
        .i_mask_field (sr_mask_r),
        .i_pin_level  (i_sync_ref_pin),
        .o_sync_ref   (o_sync_ref_internal)
    );

    // Helper: high during reset and in the first cycle after its release
    logic first_r;
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            first_r <= 1'b1;
        else
            first_r <= 1'b0;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_wr_pd;
        i_reg_wr_en && hit(i_reg_addr, PDSR_OFS_PWR_DOWN);
    endsequence

    sequence s_wr_cpl;
        i_reg_wr_en && hit(i_reg_addr, PDSR_OFS_IN_COUPL);
    endsequence

    chk_global_write_gate: assert property (
        s_wr_pd ##0 (!pin_ovr_r && !i_reg_wr_data[PDSR_POS_PIN_OVR])
        |=> !global_pd_r)
        else $error("global bit taken without override");

    chk_global_pd_on: assert property (
        s_wr_pd ##0 (i_reg_wr_data[7:6] == 2'h3) |=> ##1 o_global_powerdown)
        else $error("global power-down did not reach output");

    chk_pin_ignored: assert property (
        pin_ovr_r && !global_pd_r |=> !o_global_powerdown)
        else $error("pin still controls power-down under override");

    chk_pin_follows: assert property (
        !pin_ovr_r |=> o_global_powerdown == $past(i_powerdown_pin))
        else $error("pin power-down not followed");

    chk_mask_select: assert property (
        i_mask_powerdown_enable && mask_sel_r && i_mask2_core == 8'hff
        |=> o_channel_one_powerdown && o_channel_two_powerdown)
        else $error("second mask not applied");

    chk_mask_enable_off: assert property (
        !i_mask_powerdown_enable |=> !o_channel_one_powerdown && !o_channel_two_powerdown)
        else $error("mask power-down without enable");

    chk_channel_codes: assert property (
        i_mask_powerdown_enable && !mask_sel_r && i_mask1_core == 8'h0f
        |=> !o_channel_one_powerdown && o_channel_two_powerdown)
        else $error("mask code 0f must power down channel two only");

    chk_cm_raise: assert property (
        s_wr_cpl ##0 !i_reg_wr_data[0] |=> ##1 o_common_mode_output_raise)
        else $error("common-mode raise missing for AC coupling");

    chk_sr_hicm: assert property (
        ##1 o_sync_ref_high_common_mode_enable == $past(sr_hicm_r))
        else $error("high common-mode enable not following field");

    chk_reset_zero: assert property (
        first_r |-> {global_pd_r, pin_ovr_r, mask_sel_r, in_dc_r, sr_hicm_r,
                     sr_level_r, sr_sw_en_r, sr_mask_r} == 9'h000)
        else $error("field not zero after reset");

endmodule

`default_nettype wire

// [bench/pdsr_host_model.sv]
// Host model: a serial-interface controller issuing register strobes.
// Assumes the bank shares its clock and samples strobes on rising edges.
`default_nettype none

module pdsr_host_model
(
    // Clock
    input  wire logic  i_ref_clk,
    // Register strobes towards the bank
    output logic       o_wr_en,
    output logic       o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import pdsr_pkg::*;

    logic ovr_r = 1'b0; // Override value this host last wrote

    // Idle bus from time zero
    initial
    begin
        o_wr_en   = 1'b0;
        o_rd_en   = 1'b0;
        o_addr    = 8'h00;
        o_wr_data = 8'h00;
    end

    // Bits a careful host may set per offset; all else stays zero
    function automatic logic [7:0] legal(input logic [7:0] a);
        case (a)
            PDSR_OFS_PWR_DOWN: return 8'he0;
            PDSR_OFS_IN_COUPL: return 8'h01;
            PDSR_OFS_SR_LEVEL: return 8'h03;
            PDSR_OFS_SR_SRC:   return 8'hb0;
            default:           return 8'h00;
        endcase
    endfunction

    // One strobe pulse; a random gap first makes the host prompt or slow
    task automatic strobe(input bit is_wr, input logic [7:0] a, input logic [7:0] d);
        repeat ($urandom_range(0, 2)) @(posedge i_ref_clk);
        @(posedge i_ref_clk);
        o_wr_en   <= is_wr;
        o_rd_en   <= !is_wr;
        o_addr    <= a;
        o_wr_data <= d;
        @(posedge i_ref_clk);
        o_wr_en   <= 1'b0;
        o_rd_en   <= 1'b0;
    endtask

    // Write; raw bypasses the host's discipline for refusal tests
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw, output logic [7:0] v);
        v = d;
        if (!raw)
        begin
            v = v & legal(a);
            if (a == PDSR_OFS_SR_SRC)
                v[4] = v[5];
            if (a == PDSR_OFS_PWR_DOWN && !(ovr_r && v[6]))
                v[7] = 1'b0;
        end
        if (a == PDSR_OFS_PWR_DOWN)
            ovr_r = v[6];
        strobe(1'b1, a, v);
    endtask
endmodule

`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the power-down and timing-reference registers.
// Assumes the host model is the only source of register strobes.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pdsr_pkg::*;

    // Clock, reset, pins and bank outputs
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        pd_pin  = 1'b0;
    logic        sr_pin  = 1'b0;
    logic        mask_en = 1'b0;
    logic [7:0]  mask1   = 8'h00;
    logic [7:0]  mask2   = 8'h00;
    wire logic [5:0] ctrl;  // One bit per converter control output of the bank, so a net
    // Shadow of stored fields and the pending-read notes
    logic [7:0]  s26 = 8'h00;
    logic [7:0]  s4f = 8'h00;
    logic [7:0]  s53 = 8'h00;
    logic [7:0]  s54 = 8'h00;
    logic [15:0] q[$];
    int          err_total  = 0;
    int          n_compared = 0;
    int          seed;
    int          k;
    logic [7:0]  offs [4] = '{PDSR_OFS_PWR_DOWN, PDSR_OFS_IN_COUPL, PDSR_OFS_SR_LEVEL, PDSR_OFS_SR_SRC};
    logic [7:0]  mtab [4] = '{8'h0f, 8'hf0, 8'hff, 8'h00};

    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    pdsr_regs #(.ADDR_W(8), .DATA_W(8)) i_pdsr_regs
    (
        .i_ref_clk                          (ref_clk),
        .i_rstn                             (rstn),
        .i_reg_wr_en                        (wr_en),
        .i_reg_rd_en                        (rd_en),
        .i_reg_addr                         (addr),
        .i_reg_wr_data                      (wr_data),
        .o_reg_rd_data                      (rd_data),
        .o_reg_rd_valid                     (rd_valid),
        .i_powerdown_pin                    (pd_pin),
        .i_sync_ref_pin                     (sr_pin),
        .i_mask_powerdown_enable            (mask_en),
        .i_mask1_core                       (mask1),
        .i_mask2_core                       (mask2),
        .o_global_powerdown                 (ctrl[5]),
        .o_channel_one_powerdown            (ctrl[4]),
        .o_channel_two_powerdown            (ctrl[3]),
        .o_common_mode_output_raise         (ctrl[2]),
        .o_sync_ref_high_common_mode_enable (ctrl[1]),
        .o_sync_ref_internal                (ctrl[0])
    );

    pdsr_host_model i_pdsr_host_model
    (
        .i_ref_clk (ref_clk),
        .o_wr_en   (wr_en),
        .o_rd_en   (rd_en),
        .o_addr    (addr),
        .o_wr_data (wr_data)
    );

    // Count and report one comparison
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Expected read value; unmapped offsets read zero
    function automatic logic [7:0] shadow(input logic [7:0] a);
        case (a)
            PDSR_OFS_PWR_DOWN: return s26;
            PDSR_OFS_IN_COUPL: return s4f;
            PDSR_OFS_SR_LEVEL: return s53;
            PDSR_OFS_SR_SRC:   return s54;
            default:           return 8'h00;
        endcase
    endfunction

    // Write and track what the bank stores; reserved bits are dropped
    task automatic put(input logic [7:0] a, input logic [7:0] d, input bit raw);
        logic [7:0] v;
        begin
            i_pdsr_host_model.wr(a, d, raw, v);
            v = v & i_pdsr_host_model.legal(a);
            case (a)
                PDSR_OFS_PWR_DOWN: s26 = {v[7] & (s26[6] | v[6]), v[6:5], 5'h00};
                PDSR_OFS_IN_COUPL: s4f = v;
                PDSR_OFS_SR_LEVEL: s53 = v;
                PDSR_OFS_SR_SRC:   s54 = v;
                default:           ;
            endcase
        end
    endtask

    // Note the expected data, then issue the read
    task automatic get(input logic [7:0] a);
        q.push_back({a, shadow(a)});
        i_pdsr_host_model.strobe(1'b0, a, 8'h00);
    endtask

    // Writes settle one edge after the write edge; look one edge later
    task automatic check_ctrl();
        logic [7:0] m;
        logic [5:0] e;
        begin
            repeat (3) @(negedge ref_clk);
            m    = s26[5] ? mask2 : mask1;
            e[5] = s26[6] ? s26[7] : pd_pin;
            e[4] = mask_en && (m[7:4] == 4'hf);
            e[3] = mask_en && (m[3:0] == 4'hf);
            e[2] = ~s4f[0];
            e[1] = s53[1];
            e[0] = (s54[5:4] == 2'h3) ? 1'b0 : (s54[7] ? s53[0] : sr_pin);
            cmp("controls", {2'h0, e}, {2'h0, ctrl});
        end
    endtask

    // Read watcher: oldest note against each valid pulse
    always @(negedge ref_clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (q.size() == 0)
                cmp("unexpected read valid", 8'h00, 8'h01);
            else
                cmp($sformatf("read of %h", q[0][15:8]), q[0][7:0], rd_data);
            if (q.size() != 0)
                void'(q.pop_front());
        end
    end

    // Verdict and end of run
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (50000) @(posedge ref_clk);
        cmp("run time limit", 8'h00, 8'h01);
        wrap_up();
    end

    initial
    begin
        seed = $urandom(32575);
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        // Reset values, then a second reset in mid-run
        for (k = 0; k < 2; k++)
        begin
            foreach (offs[j]) get(offs[j]);
            get(8'h27);
            check_ctrl();
            put(PDSR_OFS_SR_LEVEL, 8'h03, 1'b0);
            check_ctrl();
            @(posedge ref_clk);
            rstn <= 1'b0;
            repeat (3) @(posedge ref_clk);
            rstn <= 1'b1;
            s53 = 8'h00;
        end
        $display("test reset done");
        // Reserved bits and an unmapped write are not stored
        put(PDSR_OFS_IN_COUPL, 8'hff, 1'b1);
        put(8'h30, 8'hff, 1'b1);
        put(PDSR_OFS_PWR_DOWN, 8'h9f, 1'b1);
        get(PDSR_OFS_IN_COUPL);
        get(8'h30);
        get(PDSR_OFS_PWR_DOWN);
        check_ctrl();
        // Override set by the same write; undefined mask code acts unmasked
        put(PDSR_OFS_PWR_DOWN, 8'hc0, 1'b1);
        put(PDSR_OFS_SR_SRC, 8'h10, 1'b1);
        sr_pin <= 1'b1;
        get(PDSR_OFS_PWR_DOWN);
        get(PDSR_OFS_SR_SRC);
        check_ctrl();
        $display("test refusal done");
        // Override first, then global bit, over pin and mask select
        mask1 <= 8'h0f;
        mask2 <= 8'hf0;
        for (k = 0; k < 16; k++)
        begin
            @(posedge ref_clk);
            pd_pin  <= k[0];
            mask_en <= k[0] ^ k[3];
            put(PDSR_OFS_PWR_DOWN, {1'b0, k[1], k[2], 5'h00}, 1'b0);
            put(PDSR_OFS_PWR_DOWN, {k[3], k[1], k[2], 5'h00}, 1'b0);
            check_ctrl();
            get(PDSR_OFS_PWR_DOWN);
        end
        $display("test powerdown done");
        // Coupling and high common-mode bits
        for (k = 0; k < 4; k++)
        begin
            put(PDSR_OFS_IN_COUPL, {7'h00, k[0]}, 1'b0);
            put(PDSR_OFS_SR_LEVEL, {6'h00, k[1], 1'b0}, 1'b0);
            check_ctrl();
            get(PDSR_OFS_IN_COUPL);
        end
        $display("test coupling done");
        // Reference source: enable first, then the level, under both mask codes
        for (k = 0; k < 16; k++)
        begin
            @(posedge ref_clk);
            sr_pin <= k[2];
            put(PDSR_OFS_SR_SRC, {k[0], 1'b0, k[1], k[1], 4'h0}, 1'b0);
            put(PDSR_OFS_SR_LEVEL, {7'h00, k[3]}, 1'b0);
            check_ctrl();
            get(PDSR_OFS_SR_SRC);
            get(PDSR_OFS_SR_LEVEL);
        end
        $display("test reference done");
        // Random traffic and pin levels
        for (k = 0; k < 24; k++)
        begin
            @(posedge ref_clk);
            pd_pin  <= 1'($urandom_range(0, 1));
            sr_pin  <= 1'($urandom_range(0, 1));
            mask_en <= 1'($urandom_range(0, 1));
            mask1   <= mtab[$urandom_range(0, 3)];
            mask2   <= 8'($urandom_range(0, 255));
            put(offs[$urandom_range(0, 3)], 8'($urandom), 1'b0);
            get(offs[$urandom_range(0, 3)]);
            check_ctrl();
        end
        $display("test random done");
        for (k = 0; k < 20 && q.size() != 0; k++)
            @(negedge ref_clk);
        if (q.size() != 0)
            cmp("reads left unanswered", 8'h00, 8'(q.size()));
        wrap_up();
    end
endmodule

`default_nettype wire
